// ==== psi_pkg.sv ====
// constants and types for the phy status interrupt and indicator block
package psi_pkg;

  // ------------------------------------------------------------------
  // register map (printed offsets are indices, byte address = 4 x index)
  // ------------------------------------------------------------------
  localparam logic [7:0]  IDX_INT_ENABLE   = 8'h12;
  localparam logic [7:0]  IDX_STATUS_CHG   = 8'h13;
  localparam logic [7:0]  IDX_IND_CONFIG   = 8'h14;
  localparam logic [11:0] ADDR_INT_ENABLE  = {2'h0, IDX_INT_ENABLE, 2'h0};
  localparam logic [11:0] ADDR_STATUS_CHG  = {2'h0, IDX_STATUS_CHG, 2'h0};
  localparam logic [11:0] ADDR_IND_CONFIG  = {2'h0, IDX_IND_CONFIG, 2'h0};

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int BIT_AN_MSK      = 7;
  localparam int BIT_SPEED_MSK   = 6;
  localparam int BIT_DUPLEX_MSK  = 5;
  localparam int BIT_LINK_MSK    = 4;
  localparam int BIT_RSVD_EN     = 2;
  localparam int BIT_MASTER_EN   = 1;
  localparam int BIT_FORCE_IRQ   = 0;
  localparam int BIT_AN_DONE     = 7;
  localparam int BIT_SPEED_CHG   = 6;
  localparam int BIT_DUPLEX_CHG  = 5;
  localparam int BIT_LINK_CHG    = 4;
  localparam int BIT_IRQ_PEND    = 2;
  localparam int POS_SEL1        = 12;
  localparam int POS_SEL2        = 8;
  localparam int POS_DUR         = 2;
  localparam int BIT_STRETCH_EN  = 1;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [3:0] RST_SEL1       = 4'h0;
  localparam logic [3:0] RST_SEL2       = 4'h4;
  localparam logic [1:0] RST_DUR        = 2'h0;
  localparam logic       RST_STRETCH_EN = 1'b1;

  // ------------------------------------------------------------------
  // selector codes
  // ------------------------------------------------------------------
  localparam logic [3:0] SEL_SPEED    = 4'h0;
  localparam logic [3:0] SEL_TX       = 4'h1;
  localparam logic [3:0] SEL_RX       = 4'h2;
  localparam logic [3:0] SEL_COL      = 4'h3;
  localparam logic [3:0] SEL_LINK     = 4'h4;
  localparam logic [3:0] SEL_DUPLEX   = 4'h5;
  localparam logic [3:0] SEL_UNUSED   = 4'h6;
  localparam logic [3:0] SEL_ACT      = 4'h7;
  localparam logic [3:0] SEL_ON       = 4'h8;
  localparam logic [3:0] SEL_OFF      = 4'h9;
  localparam logic [3:0] SEL_FAST     = 4'hA;
  localparam logic [3:0] SEL_SLOW     = 4'hB;
  localparam logic [3:0] SEL_LINK_RX  = 4'hC;
  localparam logic [3:0] SEL_LINK_ACT = 4'hD;
  localparam logic [3:0] SEL_DUP_COL  = 4'hE;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ      = 40_000_000;
  localparam int T30_MS      = 30;
  localparam int T60_MS      = 60;
  localparam int T100_MS     = 100;
  localparam int TICK_HZ     = 1000;
  localparam int TICK_CYC    = CLK_HZ / TICK_HZ;
  localparam int FAST_MS     = 50;
  localparam int SLOW_MS     = 250;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic link_up;
    logic speed_100;
    logic full_duplex;
    logic an_complete;
    logic tx_active;
    logic rx_active;
    logic collision;
  } psi_phy_status_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } psi_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } psi_apb_rsp_t;

endpackage : psi_pkg

// ==== psi_indicator.sv ====
// one indicator output with source selector and pulse stretching
`timescale 1ns/1ps
module psi_indicator
  import psi_pkg::*;
(
  input  wire logic            core_clk,
  input  wire logic            rstn,
  input  wire logic [3:0]      sel,
  input  wire logic            stretch_en,
  input  wire logic [6:0]      hold_ms,
  input  wire logic            ms_tick,
  input  wire logic            fast_blink,
  input  wire logic            slow_blink,
  input  wire psi_phy_status_t st,
  output logic                 ind_r
);

  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  logic       tog_r;
  logic       tog_nxt;
  logic       ind_nxt;
  logic       ev;
  logic       comb;
  logic       stretched;

  // ------------------------------------------------------------------
  // event select and stretch timer
  // ------------------------------------------------------------------
  always_comb
  begin
    comb = (sel == SEL_LINK_RX) || (sel == SEL_LINK_ACT) || (sel == SEL_DUP_COL);
    case (sel)
      SEL_TX:       ev = st.tx_active;
      SEL_RX:       ev = st.rx_active;
      SEL_COL:      ev = st.collision;
      SEL_ACT:      ev = st.tx_active | st.rx_active;
      SEL_LINK_RX:  ev = st.rx_active;
      SEL_LINK_ACT: ev = st.tx_active | st.rx_active;
      SEL_DUP_COL:  ev = st.collision;
      default:      ev = 1'b0;
    endcase
    cnt_nxt = cnt_r;
    tog_nxt = tog_r;
    if (ev)
    begin
      cnt_nxt = hold_ms;
    end
    else if (ms_tick && cnt_r != 7'h00)
    begin
      cnt_nxt = cnt_r - 7'h01;
    end
    // combined modes blink once per stretched event
    if (comb && ms_tick && cnt_r == 7'h01)
    begin
      tog_nxt = ~tog_r;
    end
    if (comb && ev && cnt_r == 7'h00)
    begin
      tog_nxt = ~tog_r;
    end
    stretched = ev | (cnt_r != 7'h00);
    case (sel)
      SEL_SPEED:    ind_nxt = st.speed_100;
      SEL_TX, SEL_RX, SEL_COL, SEL_ACT:
        ind_nxt = stretch_en ? stretched : ev;
      SEL_LINK:     ind_nxt = st.link_up;
      SEL_DUPLEX:   ind_nxt = st.full_duplex;
      SEL_ON:       ind_nxt = 1'b1;
      SEL_OFF:      ind_nxt = 1'b0;
      SEL_FAST:     ind_nxt = fast_blink;
      SEL_SLOW:     ind_nxt = slow_blink;
      SEL_LINK_RX:  ind_nxt = st.link_up ^ tog_r;
      SEL_LINK_ACT: ind_nxt = st.link_up ^ tog_r;
      SEL_DUP_COL:  ind_nxt = st.full_duplex ^ tog_r;
      default:      ind_nxt = 1'b0;
    endcase
    if (!comb)
    begin
      tog_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_r <= 7'h00;
      tog_r <= 1'b0;
      ind_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tog_r <= tog_nxt;
      ind_r <= ind_nxt;
    end
  end

endmodule : psi_indicator

// ==== psi_top.sv ====
// phy status change flags, management interrupt and indicator selection
//
// Notes on behaviour
// - master enable gates flag interrupts but not the force bit, resets off
// - test force bit asserts interrupt output
// - speed change flag set, cleared by read
// - duplex change flag set, cleared by read
// - link change flag set, cleared by read
// - negotiation done flag set, cleared by read
// - pending bit shows interrupt pending
// - first selector resets to speed display
// - selector code map for indicator sources
// - activity codes stretched, status codes continuous
// - combined link and duplex modes
// - second selector resets to link display
// - link modes solid, events blink
// - duplex mode solid, collisions blink
// - combined modes always stretch
// - per event masks, reset zero
// - stretch duration 30, 60, 100 ms
// - global stretch enable, resets on
`timescale 1ns/1ps
module psi_top
  import psi_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   rstn,
  input  wire psi_pkg::psi_apb_req_t  apb_req,
  output psi_pkg::psi_apb_rsp_t       apb_rsp,
  input  wire psi_pkg::psi_phy_status_t phy_st,
  output logic                        mgmt_irq_n,
  output logic                        first_indicator,
  output logic                        second_indicator
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    PSI_IDLE   = 2'b01,
    PSI_ACCESS = 2'b10
  } psi_bus_state_t;

  psi_bus_state_t  bus_r;
  psi_bus_state_t  bus_nxt;
  psi_apb_rsp_t    rsp_r;
  psi_apb_rsp_t    rsp_nxt;
  logic [7:0]      en_r;
  logic [7:0]      en_nxt;
  logic [3:0]      sel1_r;
  logic [3:0]      sel1_nxt;
  logic [3:0]      sel2_r;
  logic [3:0]      sel2_nxt;
  logic [1:0]      dur_r;
  logic [1:0]      dur_nxt;
  logic            str_en_r;
  logic            str_en_nxt;
  logic            speed_chg_r;
  logic            speed_chg_nxt;
  logic            duplex_chg_r;
  logic            duplex_chg_nxt;
  logic            link_chg_r;
  logic            link_chg_nxt;
  logic            an_done_r;
  logic            an_done_nxt;
  logic            prev_speed_r;
  logic            prev_duplex_r;
  logic            prev_link_r;
  logic            prev_an_r;
  logic            prev_valid_r;
  logic            irq_n_nxt;
  logic            irq_n_r;
  logic            pend;
  logic            access;
  logic            wr;
  logic            rd_chg;
  logic [6:0]      hold_ms;
  logic [15:0]     tick_cnt_r;
  logic [15:0]     tick_cnt_nxt;
  logic            ms_tick_r;
  logic            ms_tick_nxt;
  logic [7:0]      fast_cnt_r;
  logic [7:0]      fast_cnt_nxt;
  logic [7:0]      slow_cnt_r;
  logic [7:0]      slow_cnt_nxt;
  logic            fast_r;
  logic            fast_nxt;
  logic            slow_r;
  logic            slow_nxt;

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);
  localparam logic [7:0]  FAST_LAST = 8'(FAST_MS - 1);
  localparam logic [7:0]  SLOW_LAST = 8'(SLOW_MS - 1);
  localparam logic [6:0]  HOLD_30   = 7'(T30_MS);
  localparam logic [6:0]  HOLD_60   = 7'(T60_MS);
  localparam logic [6:0]  HOLD_100  = 7'(T100_MS);

  // ------------------------------------------------------------------
  // apb slave, answers in the first access cycle
  // ------------------------------------------------------------------
  always_comb
  begin
    access  = apb_req.psel && apb_req.penable && (bus_r == PSI_ACCESS);
    wr      = access && apb_req.pwrite;
    rd_chg  = access && !apb_req.pwrite && (apb_req.paddr == ADDR_STATUS_CHG);
    bus_nxt = bus_r;
    rsp_nxt = '0;
    case (bus_r)
      PSI_IDLE:
      begin
        if (apb_req.psel && !apb_req.penable)
        begin
          bus_nxt = PSI_ACCESS;
        end
      end
      PSI_ACCESS:
      begin
        bus_nxt = PSI_IDLE;
      end
      default:
      begin
        bus_nxt = PSI_IDLE;
      end
    endcase
    // answer registered in setup so pready is high in first access cycle
    if (bus_r == PSI_IDLE && apb_req.psel && !apb_req.penable)
    begin
      rsp_nxt.pready = 1'b1;
      if (apb_req.paddr == ADDR_INT_ENABLE)
      begin
        rsp_nxt.prdata = {24'h000000, en_r};
      end
      else if (apb_req.paddr == ADDR_STATUS_CHG)
      begin
        rsp_nxt.prdata[BIT_AN_DONE]    = an_done_r;
        rsp_nxt.prdata[BIT_SPEED_CHG]  = speed_chg_r;
        rsp_nxt.prdata[BIT_DUPLEX_CHG] = duplex_chg_r;
        rsp_nxt.prdata[BIT_LINK_CHG]   = link_chg_r;
        rsp_nxt.prdata[BIT_IRQ_PEND]   = pend;
      end
      else if (apb_req.paddr == ADDR_IND_CONFIG)
      begin
        rsp_nxt.prdata[POS_SEL1 +: 4]      = sel1_r;
        rsp_nxt.prdata[POS_SEL2 +: 4]      = sel2_r;
        rsp_nxt.prdata[POS_DUR +: 2]       = dur_r;
        rsp_nxt.prdata[BIT_STRETCH_EN]     = str_en_r;
      end
      else
      begin
        rsp_nxt.pslverr = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------------
  always_comb
  begin
    en_nxt     = en_r;
    sel1_nxt   = sel1_r;
    sel2_nxt   = sel2_r;
    dur_nxt    = dur_r;
    str_en_nxt = str_en_r;
    if (wr && apb_req.paddr == ADDR_INT_ENABLE)
    begin
      en_nxt = apb_req.pwdata[7:0];
    end
    else if (wr && apb_req.paddr == ADDR_IND_CONFIG)
    begin
      sel1_nxt   = apb_req.pwdata[POS_SEL1 +: 4];
      sel2_nxt   = apb_req.pwdata[POS_SEL2 +: 4];
      dur_nxt    = apb_req.pwdata[POS_DUR +: 2];
      str_en_nxt = apb_req.pwdata[BIT_STRETCH_EN];
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bus_r    <= PSI_IDLE;
      rsp_r    <= '0;
      en_r     <= 8'h00;
      sel1_r   <= RST_SEL1;
      sel2_r   <= RST_SEL2;
      dur_r    <= RST_DUR;
      str_en_r <= RST_STRETCH_EN;
    end
    else
    begin
      bus_r    <= bus_nxt;
      rsp_r    <= rsp_nxt;
      en_r     <= en_nxt;
      sel1_r   <= sel1_nxt;
      sel2_r   <= sel2_nxt;
      dur_r    <= dur_nxt;
      str_en_r <= str_en_nxt;
    end
  end

  // ------------------------------------------------------------------
  // change flags and interrupt
  // ------------------------------------------------------------------
  always_comb
  begin
    speed_chg_nxt  = rd_chg ? 1'b0 : speed_chg_r;
    duplex_chg_nxt = rd_chg ? 1'b0 : duplex_chg_r;
    link_chg_nxt   = rd_chg ? 1'b0 : link_chg_r;
    an_done_nxt    = rd_chg ? 1'b0 : an_done_r;
    // set wins over the read clear
    if (prev_valid_r && phy_st.speed_100 != prev_speed_r)
    begin
      speed_chg_nxt = 1'b1;
    end
    if (prev_valid_r && phy_st.full_duplex != prev_duplex_r)
    begin
      duplex_chg_nxt = 1'b1;
    end
    if (prev_valid_r && phy_st.link_up != prev_link_r)
    begin
      link_chg_nxt = 1'b1;
    end
    if (phy_st.an_complete && !prev_an_r)
    begin
      an_done_nxt = 1'b1;
    end
    pend = en_r[BIT_FORCE_IRQ]
         | (en_r[BIT_MASTER_EN]
            & ((en_r[BIT_AN_MSK] & an_done_r)
             | (en_r[BIT_SPEED_MSK] & speed_chg_r)
             | (en_r[BIT_DUPLEX_MSK] & duplex_chg_r)
             | (en_r[BIT_LINK_MSK] & link_chg_r)));
    irq_n_nxt = ~pend;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      speed_chg_r   <= 1'b0;
      duplex_chg_r  <= 1'b0;
      link_chg_r    <= 1'b0;
      an_done_r     <= 1'b0;
      prev_speed_r  <= 1'b0;
      prev_duplex_r <= 1'b0;
      prev_link_r   <= 1'b0;
      prev_an_r     <= 1'b0;
      prev_valid_r  <= 1'b0;
      irq_n_r       <= 1'b1;
    end
    else
    begin
      speed_chg_r   <= speed_chg_nxt;
      duplex_chg_r  <= duplex_chg_nxt;
      link_chg_r    <= link_chg_nxt;
      an_done_r     <= an_done_nxt;
      prev_speed_r  <= phy_st.speed_100;
      prev_duplex_r <= phy_st.full_duplex;
      prev_link_r   <= phy_st.link_up;
      prev_an_r     <= phy_st.an_complete;
      prev_valid_r  <= 1'b1;
      irq_n_r       <= irq_n_nxt;
    end
  end

  // ------------------------------------------------------------------
  // millisecond tick and blink dividers
  // ------------------------------------------------------------------
  always_comb
  begin
    ms_tick_nxt  = (tick_cnt_r == TICK_LAST);
    tick_cnt_nxt = ms_tick_nxt ? 16'h0000 : tick_cnt_r + 16'h0001;
    fast_cnt_nxt = fast_cnt_r;
    slow_cnt_nxt = slow_cnt_r;
    fast_nxt     = fast_r;
    slow_nxt     = slow_r;
    if (ms_tick_r)
    begin
      fast_cnt_nxt = (fast_cnt_r == FAST_LAST) ? 8'h00 : fast_cnt_r + 8'h01;
      slow_cnt_nxt = (slow_cnt_r == SLOW_LAST) ? 8'h00 : slow_cnt_r + 8'h01;
      fast_nxt     = (fast_cnt_r == FAST_LAST) ? ~fast_r : fast_r;
      slow_nxt     = (slow_cnt_r == SLOW_LAST) ? ~slow_r : slow_r;
    end
    case (dur_r)
      2'h0:    hold_ms = HOLD_30;
      2'h1:    hold_ms = HOLD_60;
      2'h2:    hold_ms = HOLD_100;
      default: hold_ms = HOLD_100;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tick_cnt_r <= 16'h0000;
      ms_tick_r  <= 1'b0;
      fast_cnt_r <= 8'h00;
      slow_cnt_r <= 8'h00;
      fast_r     <= 1'b0;
      slow_r     <= 1'b0;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_nxt;
      ms_tick_r  <= ms_tick_nxt;
      fast_cnt_r <= fast_cnt_nxt;
      slow_cnt_r <= slow_cnt_nxt;
      fast_r     <= fast_nxt;
      slow_r     <= slow_nxt;
    end
  end

  // ------------------------------------------------------------------
  // indicators
  // ------------------------------------------------------------------
  psi_indicator u_ind1 (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .sel        (sel1_r),
    .stretch_en (str_en_r),
    .hold_ms    (hold_ms),
    .ms_tick    (ms_tick_r),
    .fast_blink (fast_r),
    .slow_blink (slow_r),
    .st         (phy_st),
    .ind_r      (first_indicator)
  );

  psi_indicator u_ind2 (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .sel        (sel2_r),
    .stretch_en (str_en_r),
    .hold_ms    (hold_ms),
    .ms_tick    (ms_tick_r),
    .fast_blink (fast_r),
    .slow_blink (slow_r),
    .st         (phy_st),
    .ind_r      (second_indicator)
  );

  always_comb
  begin
    apb_rsp    = rsp_r;
    mgmt_irq_n = irq_n_r;
  end

endmodule : psi_top

// ==== psi_status_checker.sv ====
// port checks for the status interrupt and indicator block
`timescale 1ns/1ps
module psi_status_checker
(
  input wire logic                     core_clk,
  input wire logic                     rstn,
  input wire psi_pkg::psi_apb_req_t    apb_req,
  input wire psi_pkg::psi_apb_rsp_t    apb_rsp,
  input wire psi_pkg::psi_phy_status_t phy_st,
  input wire logic                     mgmt_irq_n,
  input wire logic                     first_indicator,
  input wire logic                     second_indicator
);
  import psi_pkg::*;
  logic        wr_ok;
  logic [15:0] ctl_r;
  logic [15:0] ctl_nxt;
  logic [15:0] cfg_r;
  logic [15:0] cfg_nxt;
  logic [3:0]  sel1;

  // ----
  // shadow of written registers
  // ----
  assign wr_ok = apb_req.psel & apb_req.penable & apb_req.pwrite & apb_rsp.pready;
  assign sel1  = cfg_r[15:12];
  always_comb
  begin
    ctl_nxt = ctl_r;
    cfg_nxt = cfg_r;
    if (wr_ok && apb_req.paddr == ADDR_INT_ENABLE)
      ctl_nxt = apb_req.pwdata[15:0];
    if (wr_ok && apb_req.paddr == ADDR_IND_CONFIG)
      cfg_nxt = apb_req.pwdata[15:0];
  end
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      ctl_r <= 16'h0000;
      cfg_r <= 16'h0402;
    end
    else
    begin
      ctl_r <= ctl_nxt;
      cfg_r <= cfg_nxt;
    end

  // ----
  // properties
  // ----
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_irq_off;
    (!ctl_r[BIT_MASTER_EN] && !ctl_r[BIT_FORCE_IRQ]) [*2] |-> mgmt_irq_n;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq low while disabled");
  property p_force;
    ctl_r[BIT_FORCE_IRQ] [*2] |-> !mgmt_irq_n;
  endproperty
  a_force: assert property (p_force) else $error("forced irq not low");
  property p_pend_mirror;
    apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.paddr == ADDR_STATUS_CHG
      |-> apb_rsp.prdata[BIT_IRQ_PEND] == !mgmt_irq_n;
  endproperty
  a_pend_mirror: assert property (p_pend_mirror) else $error("pending bit differs");
  property p_link_irq;
    ctl_r[BIT_MASTER_EN] && ctl_r[BIT_LINK_MSK] && $changed(phy_st.link_up)
      |-> ##[1:3] !mgmt_irq_n;
  endproperty
  a_link_irq: assert property (p_link_irq) else $error("link change no irq");
  property p_speed_sel;
    (sel1 == SEL_SPEED) [*2] |-> first_indicator == $past(phy_st.speed_100);
  endproperty
  a_speed_sel: assert property (p_speed_sel) else $error("speed display wrong");
  property p_on_off;
    (sel1 == SEL_ON || sel1 == SEL_OFF) [*2] |-> first_indicator == ($past(sel1) == SEL_ON);
  endproperty
  a_on_off: assert property (p_on_off) else $error("test on off wrong");
  property p_second_link;
    (cfg_r[11:8] == SEL_LINK) [*2] |-> second_indicator == $past(phy_st.link_up);
  endproperty
  a_second_link: assert property (p_second_link) else $error("link display wrong");
  property p_tx_plain;
    (sel1 == SEL_TX && !cfg_r[BIT_STRETCH_EN]) [*2] |-> first_indicator == $past(phy_st.tx_active);
  endproperty
  a_tx_plain: assert property (p_tx_plain) else $error("unstretched tx wrong");
  property p_tx_stretch;
    sel1 == SEL_TX && cfg_r[BIT_STRETCH_EN] && $fell(phy_st.tx_active) |=> first_indicator [*8];
  endproperty
  a_tx_stretch: assert property (p_tx_stretch) else $error("tx not stretched");
  c_force: cover property (!mgmt_irq_n);
  c_err: cover property (apb_rsp.pslverr);
  c_comb: cover property (sel1 == SEL_LINK_RX && !first_indicator);
endmodule : psi_status_checker

bind psi_top psi_status_checker i_chk (.core_clk(core_clk), .rstn(rstn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .phy_st(phy_st), .mgmt_irq_n(mgmt_irq_n),
  .first_indicator(first_indicator), .second_indicator(second_indicator));

// ==== psi_mgmt_model.sv ====
// station management bus master model
`timescale 1ns/1ps
module psi_mgmt_model
(
  input  wire logic                  core_clk,
  output psi_pkg::psi_apb_req_t      req,
  input  wire psi_pkg::psi_apb_rsp_t rsp
);
  import psi_pkg::*;
  initial req = '0;

  task automatic xfer(input logic wr, input logic [11:0] a, input logic [15:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge core_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
             pwdata: {16'h0000, d & 16'hFFFB}};
    @(posedge core_clk);
    req.penable <= 1'b1;
    do @(posedge core_clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    req.pwdata <= ~req.pwdata;
  endtask : xfer
endmodule : psi_mgmt_model

// ==== testbench.sv ====
// self-checking bench for the status interrupt and indicator block
`timescale 1ns/1ps
module testbench;
  import psi_pkg::*;
  logic            core_clk;
  logic            rstn;
  psi_apb_req_t    apb_req;
  psi_apb_rsp_t    apb_rsp;
  psi_phy_status_t phy_st;
  logic            mgmt_irq_n;
  logic            first_indicator;
  logic            second_indicator;
  int              num_errors;
  int              n_tests;
  int              cyc;
  logic [31:0]     rd;
  logic            err;

  psi_top i_dut (.core_clk(core_clk), .rstn(rstn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .phy_st(phy_st), .mgmt_irq_n(mgmt_irq_n), .first_indicator(first_indicator),
    .second_indicator(second_indicator));
  psi_mgmt_model i_mgmt (.core_clk(core_clk), .req(apb_req), .rsp(apb_rsp));

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ----
  // helpers
  // ----
  task automatic conclude;
    $display("counts: %0d compares, %0d mismatches", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic xerr);
    i_mgmt.xfer(1'b0, a, 16'h0000, rd, err);
    check(rd, exp);
    check(32'(err), 32'(xerr));
  endtask : rd_chk
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    i_mgmt.xfer(1'b1, a, d, rd, err);
  endtask : wr
  task automatic setphy(input logic [6:0] v);
    @(posedge core_clk);
    phy_st <= v;
  endtask : setphy
  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cycles
  function automatic logic exp_ind(input logic [3:0] c, input psi_phy_status_t s);
    case (c)
      4'h0: return s.speed_100;
      4'h1: return s.tx_active;
      4'h2: return s.rx_active;
      4'h3: return s.collision;
      4'h4: return s.link_up;
      4'h5: return s.full_duplex;
      4'h7: return s.tx_active | s.rx_active;
      4'h8: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : exp_ind

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      num_errors++;
      conclude();
    end
  end

  // ----
  // tests
  // ----
  initial
  begin
    rstn = 1'b0;
    phy_st = '0;
    cyc = 0;
    num_errors = 0;
    n_tests = 0;
    cycles(4);
    rstn <= 1'b1;
    rd_chk(ADDR_INT_ENABLE, 32'h0000_0000, 1'b0);
    rd_chk(ADDR_IND_CONFIG, 32'h0000_0402, 1'b0);
    rd_chk(ADDR_STATUS_CHG, 32'h0000_0000, 1'b0);
    check(32'(mgmt_irq_n), 32'h1);
    $display("test reset values done");
    rd_chk(12'h07C, 32'h0000_0000, 1'b1);
    wr(12'h07C, 16'hFFFF);
    rd_chk(ADDR_INT_ENABLE, 32'h0000_0000, 1'b0);
    $display("test unmapped done");
    wr(ADDR_INT_ENABLE, 16'h0001);
    cycles(2);
    check(32'(mgmt_irq_n), 32'h0);
    rd_chk(ADDR_STATUS_CHG, 32'h0000_0004, 1'b0);
    wr(ADDR_INT_ENABLE, 16'h0000);
    cycles(2);
    check(32'(mgmt_irq_n), 32'h1);
    $display("test force done");
    wr(ADDR_INT_ENABLE, 16'h0002);
    setphy(7'h70);
    cycles(3);
    check(32'(mgmt_irq_n), 32'h1);
    rd_chk(ADDR_STATUS_CHG, 32'h0000_0070, 1'b0);
    rd_chk(ADDR_STATUS_CHG, 32'h0000_0000, 1'b0);
    wr(ADDR_INT_ENABLE, 16'h0052);
    setphy(7'h30);
    cycles(3);
    check(32'(mgmt_irq_n), 32'h0);
    rd_chk(ADDR_STATUS_CHG, 32'h0000_0014, 1'b0);
    cycles(2);
    check(32'(mgmt_irq_n), 32'h1);
    wr(ADDR_INT_ENABLE, 16'h00F0);
    setphy(7'h38);
    cycles(3);
    check(32'(mgmt_irq_n), 32'h1);
    rd_chk(ADDR_STATUS_CHG, 32'h0000_0080, 1'b0);
    wr(ADDR_INT_ENABLE, 16'h0000);
    $display("test change flags done");
    wr(ADDR_IND_CONFIG, 16'h0500);
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 12; c++)
      begin
        setphy(p ? 7'h2A : 7'h55);
        wr(ADDR_IND_CONFIG, {c[3:0], 4'h5, 8'h00});
        cycles(2);
        check(32'(first_indicator), 32'(exp_ind(c[3:0], phy_st)));
        check(32'(second_indicator), 32'(phy_st.full_duplex));
      end
    $display("test selector codes done");
    setphy(7'h00);
    wr(ADDR_IND_CONFIG, 16'h1002);
    setphy(7'h04);
    setphy(7'h00);
    cycles(200);
    check(32'(first_indicator), 32'h1);
    wr(ADDR_IND_CONFIG, 16'h1000);
    cycles(2);
    check(32'(first_indicator), 32'h0);
    $display("test stretch done");
    @(posedge core_clk);
    rstn <= 1'b0;
    cycles(2);
    rstn <= 1'b1;
    setphy(7'h50);
    wr(ADDR_IND_CONFIG, 16'hE402);
    cycles(2);
    check(32'(first_indicator), 32'h1);
    check(32'(second_indicator), 32'h1);
    setphy(7'h40);
    cycles(2);
    check(32'(first_indicator), 32'h0);
    wr(ADDR_IND_CONFIG, 16'hC000);
    cycles(2);
    check(32'(first_indicator), 32'h1);
    setphy(7'h42);
    setphy(7'h40);
    cycles(3);
    check(32'(first_indicator), 32'h0);
    cycles(100);
    check(32'(first_indicator), 32'h0);
    $display("test combined modes done");
    conclude();
  end
endmodule : testbench
